// ==== shared/tfp_cfg.svh ====
// Constants of the trigger function programmer: offsets, fields, reset values, timing.
// Assumes a 200 MHz hclk; included by the package, the bench and every design file but tfp_product.
`ifndef TFP_CFG_SVH
`define TFP_CFG_SVH

`define TFP_NCH 4
`define TFP_NPROD 2
`define TFP_PROD_W 1
`define TFP_TERM_W 8
`define TFP_SYNC_W 5

// Register byte addresses
`define TFP_ADDR_CMD 8'h00
`define TFP_ADDR_STATUS 8'h04
`define TFP_ADDR_TERMS 8'h08
`define TFP_ADDR_CHAN 8'h0C

// Command word fields
`define TFP_CMD_OP_LSB 0
`define TFP_CMD_CH_LSB 4

// Reset values and the deflection limit
`define TFP_RST_TERMS 8'h01
`define TFP_RST_TTL 4'hF
`define TFP_RST_HIMP 4'hF
`define TFP_RST_DISP 4'h1
`define TFP_RST_DEFL 16'h3333
`define TFP_DEFL_MAX 4'hF

// Timing
`define TFP_CLK_PERIOD_NS 5
`define TFP_DONE_MSG_MS 1000
`define TFP_DONE_MSG_CYCLES (`TFP_DONE_MSG_MS * 1000000 / `TFP_CLK_PERIOD_NS)
`define TFP_SELFTEST_CYCLES 1024
`define TFP_FLASH_MS 250
`define TFP_FLASH_CYCLES (`TFP_FLASH_MS * 1000000 / `TFP_CLK_PERIOD_NS)

`endif

// ==== shared/tfp_pkg.sv ====
// Types of the trigger function programmer.
// Assumes tfp_cfg.svh is on the include path.
`include "tfp_cfg.svh"

package tfp_pkg;

   typedef enum logic [1:0] {TFP_MSG_BUSY, TFP_MSG_DONE, TFP_MSG_RUN} tfp_msg_t;

   typedef enum logic [3:0] {
      TFP_OP_NOP, TFP_OP_PROGRAM_SELECT_TOGGLE, TFP_OP_CHAN, TFP_OP_CLEAR, TFP_OP_OR, TFP_OP_INVERT, TFP_OP_EDGE,
      TFP_OP_GND, TFP_OP_DISP, TFP_OP_DEFL_UP, TFP_OP_DEFL_DN, TFP_OP_THRESHOLD_ENTRY, TFP_OP_IMPED, TFP_OP_LOGIC
   } tfp_op_t;

   typedef struct packed {
      logic [`TFP_SYNC_W-1:0] s1;
      logic [`TFP_SYNC_W-1:0] s2;
   } tfp_sync_t;

   typedef struct packed {
      logic trig_mode;
      tfp_msg_t msg;
      logic st_fault;
      logic [31:0] tmr;
      logic [31:0] flash_cnt;
      logic flash_ph;
      logic [1:0] sel_ch;
      logic [`TFP_PROD_W-1:0] prod;
      logic [1:0] term_ch;
      logic [`TFP_TERM_W-1:0] used;
      logic [`TFP_TERM_W-1:0] inv;
      logic [`TFP_TERM_W-1:0] edg;
      logic [3:0] gnd;
      logic [3:0] disp;
      logic [3:0] ttl;
      logic [3:0] himp;
      logic threshold_entry;
      logic [15:0] defl;
      logic [3:0] prev;
      logic trig;
      logic tview;
      logic [3:0] led_r;
      logic [3:0] led_g;
      logic lamp;
      logic busy;
      logic hrdy;
      logic [31:0] rdata;
      logic [7:0] addr;
      logic hit;
      logic wr;
   } tfp_state_t;

endpackage : tfp_pkg

// ==== design/tfp_sync.sv ====
// Two-flop synchroniser for the channel comparator and self-test fault pins.
// Assumes pins are asynchronous to hclk; only s2 leaves the module.
`timescale 1ns/100ps
`include "tfp_cfg.svh"

module tfp_sync (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Pins and synchronised copy
   input wire logic [`TFP_SYNC_W-1:0] pin_in,
   output logic [`TFP_SYNC_W-1:0] pin_sync
);

   tfp_pkg::tfp_sync_t q;
   tfp_pkg::tfp_sync_t d;

   always_comb begin
      d = q;
      d.s1 = pin_in;
      d.s2 = q.s1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pin_sync = q.s2;

endmodule : tfp_sync

// ==== design/tfp_product.sv ====
// One product (AND) term of the trigger function over the four channels.
// Assumes cur and prev are one hclk apart, both already synchronised.
`timescale 1ns/100ps

module tfp_product (
   // Channel samples
   input wire logic [3:0] cur,
   input wire logic [3:0] prev,
   // Programming of this product
   input wire logic [3:0] used,
   input wire logic [3:0] inv,
   input wire logic [3:0] edg,
   // Result
   output logic hit
);

   logic [3:0] rise;
   logic [3:0] fall;
   logic [3:0] ok;

   assign rise = cur & ~prev;
   assign fall = prev & ~cur;
   // Level terms compare with polarity, edge terms fire only on their transition
   assign ok = ~used | (edg & ~inv & rise) | (edg & inv & fall) | (~edg & (cur ^ inv));
   // An empty product never fires, so a cleared function stays silent
   assign hit = (|used) && (&ok);

endmodule : tfp_product

// ==== design/tfp_top.sv ====
// Trigger function programmer: front-panel command decode, self-test messaging,
// term programming and trigger output over an AHB-Lite register slave.
// Assumes a single hclk domain; channel and fault pins arrive asynchronously.
`timescale 1ns/100ps
`include "tfp_cfg.svh"

module tfp_top #(
   parameter int SELFTEST_CYCLES = `TFP_SELFTEST_CYCLES,
   parameter int DONE_CYCLES = `TFP_DONE_MSG_CYCLES,
   parameter int FLASH_CYCLES = `TFP_FLASH_CYCLES
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Channel comparators and self-test fault pin
   input wire logic [3:0] chan_in,
   input wire logic selftest_fault,
   // Trigger to the time base
   output logic trigger_out,
   output logic trigger_view_output,
   // Front-panel indicators
   output logic [3:0] term_led_red,
   output logic [3:0] term_led_green,
   output logic program_select_toggle_lamp_green,
   output logic [1:0] msg_code,
   output logic [3:0] chan_ground,
   output logic [3:0] chan_display
);

   tfp_pkg::tfp_state_t q;
   tfp_pkg::tfp_state_t d;

   logic [`TFP_SYNC_W-1:0] pins_s;
   logic [3:0] m;
   logic fault_s;
   logic [`TFP_NPROD-1:0] hits;
   logic [3:0] led_r_w;
   logic [3:0] led_g_w;
   logic cmd;
   tfp_pkg::tfp_op_t op;
   logic [1:0] ch;
   logic [2:0] idx;
   logic [2:0] cidx;
   logic [3:0] defl_sel;
   logic [31:0] rd_mux;

   tfp_sync u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in({selftest_fault, chan_in}),
      .pin_sync(pins_s)
   );

   assign fault_s = pins_s[4];
   // Grounding replaces the input, so level, edge and view all flatten
   assign m = pins_s[3:0] & ~q.gnd;

   genvar gp;
   genvar gc;
   generate
      for (gp = 0; gp < `TFP_NPROD; gp++) begin : g_prod
         tfp_product u_prod (
            .cur(m),
            .prev(q.prev),
            .used(q.used[gp*4 +: 4]),
            .inv(q.inv[gp*4 +: 4]),
            .edg(q.edg[gp*4 +: 4]),
            .hit(hits[gp])
         );
      end
      for (gc = 0; gc < `TFP_NCH; gc++) begin : g_led
         localparam logic [1:0] CH = 2'(gc);
         logic on;
         logic lit;
         assign on = q.used[{q.prod, CH}];
         // Edge terms blink; the colour still shows the polarity
         assign lit = on && (!q.edg[{q.prod, CH}] || q.flash_ph);
         assign led_r_w[gc] = lit && !q.inv[{q.prod, CH}];
         assign led_g_w[gc] = lit && q.inv[{q.prod, CH}];
      end
   endgenerate

   assign op = tfp_pkg::tfp_op_t'(hwdata[`TFP_CMD_OP_LSB +: 4]);
   assign ch = hwdata[`TFP_CMD_CH_LSB +: 2];
   assign idx = {q.prod, q.term_ch};
   assign cidx = {q.prod, ch};
   assign defl_sel = q.defl[{q.sel_ch, 2'b00} +: 4];
   // Commands are ignored until the self test has handed over
   assign cmd = q.busy && q.wr && q.hit && (q.addr == `TFP_ADDR_CMD) && (q.msg == tfp_pkg::TFP_MSG_RUN);

   always_comb begin
      unique case (q.addr)
         `TFP_ADDR_STATUS: rd_mux = {25'h0000000, q.threshold_entry, q.tview, q.sel_ch, q.msg, q.trig_mode};
         `TFP_ADDR_TERMS: rd_mux = {8'h00, q.edg, q.inv, q.used};
         `TFP_ADDR_CHAN: rd_mux = {q.defl, q.himp, q.ttl, q.disp, q.gnd};
         default: rd_mux = 32'h00000000;
      endcase
      if (!q.hit) begin
         rd_mux = 32'h00000000;
      end
   end

   always_comb begin
      d = q;
      // Self-test sequencing and message display
      unique case (q.msg)
         tfp_pkg::TFP_MSG_BUSY: begin
            d.st_fault = q.st_fault | fault_s;
            if (q.tmr == 32'(SELFTEST_CYCLES - 1)) begin
               // A fault freezes the busy message for good
               if (!(q.st_fault | fault_s)) begin
                  d.msg = tfp_pkg::TFP_MSG_DONE;
                  d.tmr = 32'h00000000;
               end
            end else begin
               d.tmr = q.tmr + 32'h00000001;
            end
         end
         tfp_pkg::TFP_MSG_DONE: begin
            if (q.tmr == 32'(DONE_CYCLES - 1)) begin
               d.msg = tfp_pkg::TFP_MSG_RUN;
            end else begin
               d.tmr = q.tmr + 32'h00000001;
            end
         end
         tfp_pkg::TFP_MSG_RUN: begin
         end
      endcase
      // Flash phase for edge-qualified indicators
      if (q.flash_cnt == 32'(FLASH_CYCLES - 1)) begin
         d.flash_cnt = 32'h00000000;
         d.flash_ph = !q.flash_ph;
      end else begin
         d.flash_cnt = q.flash_cnt + 32'h00000001;
      end
      // Bus slave: one wait state on every transfer so hrdata can come from a flop
      d.busy = 1'b0;
      d.hrdy = 1'b1;
      if (q.busy) begin
         d.rdata = rd_mux;
      end else if (hsel && htrans[1] && hready) begin
         d.busy = 1'b1;
         d.hrdy = 1'b0;
         d.addr = haddr[7:0];
         d.hit = (haddr[31:8] == 24'h000000);
         d.wr = hwrite;
      end
      // Front-panel commands
      if (cmd) begin
         unique case (op)
            tfp_pkg::TFP_OP_NOP: begin
            end
            tfp_pkg::TFP_OP_PROGRAM_SELECT_TOGGLE: d.trig_mode = !q.trig_mode;
            tfp_pkg::TFP_OP_CHAN: begin
               if (q.trig_mode) begin
                  d.used[cidx] = 1'b1;
                  d.inv[cidx] = 1'b0;
                  d.edg[cidx] = 1'b0;
                  d.term_ch = ch;
               end else begin
                  d.sel_ch = ch;
               end
            end
            tfp_pkg::TFP_OP_CLEAR: begin
               if (q.trig_mode) begin
                  d.used = '0;
                  d.inv = '0;
                  d.edg = '0;
                  d.prod = '0;
               end
            end
            tfp_pkg::TFP_OP_OR: begin
               if (q.trig_mode && (q.prod != `TFP_PROD_W'(`TFP_NPROD - 1))) begin
                  d.prod = q.prod + `TFP_PROD_W'(1);
               end
            end
            tfp_pkg::TFP_OP_INVERT: begin
               if (q.trig_mode && q.used[idx]) begin
                  d.inv[idx] = !q.inv[idx];
               end
            end
            tfp_pkg::TFP_OP_EDGE: begin
               if (q.trig_mode && q.used[idx]) begin
                  if (q.edg[idx]) begin
                     d.edg[idx] = 1'b0;
                  end else begin
                     // One edge channel per product
                     d.edg[{q.prod, 2'b00} +: 4] = 4'h0;
                     d.edg[idx] = 1'b1;
                  end
               end
            end
            tfp_pkg::TFP_OP_GND: if (!q.trig_mode) d.gnd[q.sel_ch] = !q.gnd[q.sel_ch];
            // Display only gates the waveform; the terms keep their inputs
            tfp_pkg::TFP_OP_DISP: if (!q.trig_mode) d.disp[q.sel_ch] = !q.disp[q.sel_ch];
            tfp_pkg::TFP_OP_DEFL_UP: begin
               if (!q.trig_mode && (defl_sel != `TFP_DEFL_MAX)) begin
                  d.defl[{q.sel_ch, 2'b00} +: 4] = defl_sel + 4'h1;
               end
            end
            tfp_pkg::TFP_OP_DEFL_DN: begin
               if (!q.trig_mode && (defl_sel != 4'h0)) begin
                  d.defl[{q.sel_ch, 2'b00} +: 4] = defl_sel - 4'h1;
               end
            end
            tfp_pkg::TFP_OP_THRESHOLD_ENTRY: if (!q.trig_mode) d.threshold_entry = !q.threshold_entry;
            tfp_pkg::TFP_OP_IMPED: if (!q.trig_mode) d.himp[q.sel_ch] = !q.himp[q.sel_ch];
            tfp_pkg::TFP_OP_LOGIC: if (!q.trig_mode) d.ttl[q.sel_ch] = !q.ttl[q.sel_ch];
            default: begin
            end
         endcase
      end
      // Trigger path
      d.prev = m;
      d.trig = (|hits) && (q.msg == tfp_pkg::TFP_MSG_RUN);
      d.tview = d.trig;
      d.led_r = led_r_w;
      d.led_g = led_g_w;
      d.lamp = d.trig_mode;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
         q.used <= `TFP_RST_TERMS;
         q.ttl <= `TFP_RST_TTL;
         q.himp <= `TFP_RST_HIMP;
         q.disp <= `TFP_RST_DISP;
         q.defl <= `TFP_RST_DEFL;
         q.hrdy <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign hreadyout = q.hrdy;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign trigger_out = q.trig;
   assign trigger_view_output = q.tview;
   assign term_led_red = q.led_r;
   assign term_led_green = q.led_g;
   assign program_select_toggle_lamp_green = q.lamp;
   assign msg_code = q.msg;
   assign chan_ground = q.gnd;
   assign chan_display = q.disp;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_accept;
      hsel && htrans[1] && hready && !q.busy;
   endsequence

   sequence s_test_pass;
      (q.msg == tfp_pkg::TFP_MSG_BUSY) ##1 (q.msg == tfp_pkg::TFP_MSG_DONE);
   endsequence

   sequence s_cleared;
      (q.used == '0) ##1 (!trigger_out && !trigger_view_output && term_led_red == 4'h0 && term_led_green == 4'h0);
   endsequence

   a_bus_wait: assert property (s_accept |=> !hreadyout ##1 hreadyout)
      else $error("transfer not answered after one wait state");
   a_bus_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_mode_toggle: assert property (cmd && op == tfp_pkg::TFP_OP_PROGRAM_SELECT_TOGGLE |=>
      (q.trig_mode != $past(q.trig_mode)) && (program_select_toggle_lamp_green == q.trig_mode))
      else $error("program select did not toggle mode and lamp");
   a_clear_all: assert property (cmd && op == tfp_pkg::TFP_OP_CLEAR && q.trig_mode |=> s_cleared)
      else $error("clear left terms or trigger active");
   a_add_term: assert property (cmd && op == tfp_pkg::TFP_OP_CHAN && q.trig_mode |=>
      q.used[$past(cidx)] && !q.inv[$past(cidx)] && !q.edg[$past(cidx)])
      else $error("channel press did not add an active-high term");
   a_level_track: assert property (q.msg == tfp_pkg::TFP_MSG_RUN && q.used == 8'h01 && q.edg == 8'h00 |=>
      trigger_out == ($past(m[0]) ^ $past(q.inv[0])))
      else $error("level term does not follow channel one");
   a_invert_flip: assert property (cmd && op == tfp_pkg::TFP_OP_INVERT && q.trig_mode && q.used[idx] |=>
      q.inv[$past(idx)] != $past(q.inv[idx]))
      else $error("invert did not flip polarity");
   a_edge_pulse: assert property (q.msg == tfp_pkg::TFP_MSG_RUN && $onehot(q.used) && q.edg == q.used && q.used[idx] |=>
      trigger_out == ($past(q.inv[idx]) ? ($past(q.prev[q.term_ch]) && !$past(m[q.term_ch])) :
      ($past(m[q.term_ch]) && !$past(q.prev[q.term_ch]))))
      else $error("edge term did not pulse on its transition");
   a_edge_cancel: assert property (cmd && op == tfp_pkg::TFP_OP_EDGE && q.trig_mode && q.edg[idx] |=>
      !q.edg[$past(idx)] && q.used[idx])
      else $error("second edge command did not cancel edge");
   a_ground_flat: assert property (q.gnd[0] && q.used == 8'h01 && q.edg == 8'h00 && !q.inv[0] |=> !trigger_out)
      else $error("grounded channel still triggers");
   a_display_free: assert property (cmd && op == tfp_pkg::TFP_OP_DISP |=>
      q.used == $past(q.used) && q.inv == $past(q.inv) && q.edg == $past(q.edg))
      else $error("display change altered the function");
   a_defl_step: assert property (cmd && op == tfp_pkg::TFP_OP_DEFL_UP && !q.trig_mode && defl_sel != 4'hF |=>
      defl_sel == $past(defl_sel) + 4'h1)
      else $error("deflection did not step up by one");
   a_test_done: assert property (s_test_pass |-> q.tmr == 32'h00000000 && !$past(q.st_fault))
      else $error("completion message shown after fault or with stale timer");
   a_fault_hold: assert property (q.msg == tfp_pkg::TFP_MSG_BUSY && q.st_fault |=>
      q.msg == tfp_pkg::TFP_MSG_BUSY)
      else $error("busy message left despite fault");

endmodule : tfp_top

// ==== verification/tfp_timebase.sv ====
// Time-base partner: counts trigger pulses and measures the last pulse width.
// Assumes trigger_out is registered on hclk and sampled on the same edge.
`timescale 1ns/100ps

module tfp_timebase (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Trigger from the block
   input wire logic trig_in,
   // Observations
   output int pulses,
   output int width
);
   int run_q;
   logic prev_q;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulses <= 0;
         width <= 0;
         run_q <= 0;
         prev_q <= 1'b0;
      end else begin
         prev_q <= trig_in;
         run_q <= trig_in ? run_q + 1 : 0;
         if (trig_in && !prev_q) pulses <= pulses + 1;
         // Width in clocks is only known once the pulse ends
         if (!trig_in && prev_q) width <= run_q;
      end
   end
endmodule : tfp_timebase

// ==== verification/tb_top.sv ====
// Self-checking bench of the trigger function programmer over its AHB-Lite port.
// Assumes short self-test, message and flash parameters; time base is modelled.
`timescale 1ns/100ps
`include "tfp_cfg.svh"

module tb_top;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [3:0] chan_in = 4'h0;
   logic selftest_fault = 1'b0;
   logic hreadyout, hresp, trigger_out, trigger_view_output, program_select_toggle_lamp_green;
   logic [31:0] hrdata, rd;
   logic [3:0] term_led_red, term_led_green, chan_ground, chan_display;
   logic [1:0] msg_code;
   int pulses, width, error_cnt, compares, p;

   always #2.5 hclk = ~hclk;

   tfp_top #(.SELFTEST_CYCLES(16), .DONE_CYCLES(20), .FLASH_CYCLES(4)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .chan_in(chan_in), .selftest_fault(selftest_fault), .trigger_out(trigger_out),
      .trigger_view_output(trigger_view_output), .term_led_red(term_led_red),
      .term_led_green(term_led_green), .program_select_toggle_lamp_green(program_select_toggle_lamp_green), .msg_code(msg_code),
      .chan_ground(chan_ground), .chan_display(chan_display));

   tfp_timebase tb_model (.hclk(hclk), .hresetn(hresetn), .trig_in(trigger_out), .pulses(pulses),
      .width(width));

   task close_out;
      if (error_cnt == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Address phase held until hready, then data phase held until hready again
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask : bus

   task cmd(input tfp_pkg::tfp_op_t op, input logic [1:0] ch);
      bus(1'b1, `TFP_ADDR_CMD, {26'h0, ch, op}, rd);
      repeat (2) @(posedge hclk);
   endtask : cmd

   // Pin to trigger takes three edges; two spare
   task set_ch(input logic [3:0] v);
      chan_in <= v;
      repeat (5) @(posedge hclk);
   endtask : set_ch

   task do_reset;
      hresetn <= 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
   endtask : do_reset

   task wait_run;
      int n;
      n = 0;
      while (msg_code !== 2'h2 && n < 500) begin
         @(posedge hclk);
         n++;
      end
   endtask : wait_run

   task flash(input logic grn, input int ch);
      logic s0, s1, v;
      s0 = 1'b0;
      s1 = 1'b0;
      repeat (14) begin
         @(posedge hclk);
         v = grn ? term_led_green[ch] : term_led_red[ch];
         s1 = s1 | (v === 1'b1);
         s0 = s0 | (v === 1'b0);
      end
      chk("led blink", 32'h3, {30'h0, s0, s1});
   endtask : flash

   task t_selftest;
      int n, m;
      n = 0;
      m = 0;
      do_reset();
      while (msg_code === 2'h0 && n < 200) begin
         @(posedge hclk);
         n++;
      end
      chk("busy long enough", 32'h1, {31'h0, n >= 16});
      while (msg_code === 2'h1 && m < 200) begin
         @(posedge hclk);
         m++;
      end
      chk("done cycles", 32'd20, m);
      chk("msg run", 32'h2, {30'h0, msg_code});
      // Threshold entry before the power cycle; the defaults must wipe it
      cmd(tfp_pkg::TFP_OP_THRESHOLD_ENTRY, 2'h0);
      bus(1'b0, `TFP_ADDR_STATUS, 32'h0, rd);
      chk("threshold entry", 32'h1, {31'h0, rd[6]});
      selftest_fault <= 1'b1;
      do_reset();
      repeat (100) @(posedge hclk);
      chk("msg fail", 32'h0, {30'h0, msg_code});
      selftest_fault <= 1'b0;
      do_reset();
      wait_run();
   endtask : t_selftest

   task t_defaults;
      bus(1'b0, `TFP_ADDR_STATUS, 32'h0, rd);
      chk("status", 32'h04, rd & 32'h7F);
      bus(1'b0, `TFP_ADDR_TERMS, 32'h0, rd);
      chk("terms", 32'h1, rd);
      bus(1'b0, `TFP_ADDR_CHAN, 32'h0, rd);
      chk("chan", 32'h3333FF10, rd);
      set_ch(4'h1);
      chk("trig one high", 32'h1, {31'h0, trigger_out});
      bus(1'b1, `TFP_ADDR_STATUS, 32'hFF, rd);
      bus(1'b0, `TFP_ADDR_STATUS, 32'h0, rd);
      chk("status ro", 32'h24, rd & 32'h7F);
      bus(1'b0, 8'h40, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : t_defaults

   task t_mode;
      cmd(tfp_pkg::TFP_OP_PROGRAM_SELECT_TOGGLE, 2'h0);
      chk("lamp on", 32'h1, {31'h0, program_select_toggle_lamp_green});
      cmd(tfp_pkg::TFP_OP_PROGRAM_SELECT_TOGGLE, 2'h0);
      chk("lamp off", 32'h0, {31'h0, program_select_toggle_lamp_green});
      cmd(tfp_pkg::TFP_OP_NOP, 2'h0);
      chk("nop keeps mode", 32'h0, {31'h0, program_select_toggle_lamp_green});
   endtask : t_mode

   task t_level;
      cmd(tfp_pkg::TFP_OP_PROGRAM_SELECT_TOGGLE, 2'h0);
      set_ch(4'hF);
      cmd(tfp_pkg::TFP_OP_CLEAR, 2'h0);
      chk("leds clear", 32'h0, {24'h0, term_led_red, term_led_green});
      chk("trig clear", 32'h0, {30'h0, trigger_out, trigger_view_output});
      cmd(tfp_pkg::TFP_OP_CHAN, 2'h1);
      chk("red added", 32'h20, {24'h0, term_led_red, term_led_green});
      set_ch(4'h2);
      chk("trig high", 32'h3, {30'h0, trigger_out, trigger_view_output});
      set_ch(4'h0);
      chk("trig low", 32'h0, {31'h0, trigger_out});
      cmd(tfp_pkg::TFP_OP_INVERT, 2'h0);
      chk("green inv", 32'h02, {24'h0, term_led_red, term_led_green});
      chk("view inv", 32'h1, {31'h0, trigger_view_output});
      set_ch(4'h2);
      chk("inv high", 32'h0, {31'h0, trigger_out});
      cmd(tfp_pkg::TFP_OP_INVERT, 2'h0);
      chk("red again", 32'h20, {24'h0, term_led_red, term_led_green});
      chk("trig again", 32'h1, {31'h0, trigger_out});
   endtask : t_level

   // The time base posts a width one edge after the pulse ends, hence the spare edge
   task t_edge;
      cmd(tfp_pkg::TFP_OP_EDGE, 2'h0);
      set_ch(4'h0);
      p = pulses;
      set_ch(4'h2);
      @(posedge hclk);
      chk("rise pulses", p + 1, pulses);
      chk("rise width", 32'h1, width);
      chk("no level", 32'h0, {31'h0, trigger_out});
      flash(1'b0, 1);
      cmd(tfp_pkg::TFP_OP_EDGE, 2'h0);
      chk("level back", 32'h1, {31'h0, trigger_out});
      chk("steady red", 32'h20, {24'h0, term_led_red, term_led_green});
      cmd(tfp_pkg::TFP_OP_EDGE, 2'h0);
      cmd(tfp_pkg::TFP_OP_INVERT, 2'h0);
      p = pulses;
      set_ch(4'h0);
      @(posedge hclk);
      chk("fall pulses", p + 1, pulses);
      chk("fall width", 32'h1, width);
      flash(1'b1, 1);
   endtask : t_edge

   task t_chan;
      cmd(tfp_pkg::TFP_OP_CLEAR, 2'h0);
      cmd(tfp_pkg::TFP_OP_CHAN, 2'h0);
      cmd(tfp_pkg::TFP_OP_PROGRAM_SELECT_TOGGLE, 2'h0);
      cmd(tfp_pkg::TFP_OP_CHAN, 2'h0);
      set_ch(4'h1);
      cmd(tfp_pkg::TFP_OP_DISP, 2'h0);
      chk("display off", 32'h0, {31'h0, chan_display[0]});
      chk("view kept", 32'h1, {31'h0, trigger_view_output});
      cmd(tfp_pkg::TFP_OP_DISP, 2'h0);
      cmd(tfp_pkg::TFP_OP_GND, 2'h0);
      repeat (4) @(posedge hclk);
      chk("grounded", 32'h1, {31'h0, chan_ground[0]});
      chk("view flat", 32'h0, {31'h0, trigger_view_output});
      cmd(tfp_pkg::TFP_OP_GND, 2'h0);
      repeat (4) @(posedge hclk);
      chk("view restored", 32'h1, {31'h0, trigger_view_output});
      cmd(tfp_pkg::TFP_OP_DEFL_UP, 2'h0);
      bus(1'b0, `TFP_ADDR_CHAN, 32'h0, rd);
      chk("defl step", 32'h4, {28'h0, rd[19:16]});
      cmd(tfp_pkg::TFP_OP_DEFL_DN, 2'h0);
      cmd(tfp_pkg::TFP_OP_IMPED, 2'h0);
      cmd(tfp_pkg::TFP_OP_LOGIC, 2'h0);
      bus(1'b0, `TFP_ADDR_CHAN, 32'h0, rd);
      chk("chan setup", 32'h3333EE10, rd);
   endtask : t_chan

   task t_sum;
      logic [3:0] v;
      cmd(tfp_pkg::TFP_OP_PROGRAM_SELECT_TOGGLE, 2'h0);
      cmd(tfp_pkg::TFP_OP_CLEAR, 2'h0);
      cmd(tfp_pkg::TFP_OP_CHAN, 2'h0);
      cmd(tfp_pkg::TFP_OP_CHAN, 2'h1);
      cmd(tfp_pkg::TFP_OP_OR, 2'h0);
      cmd(tfp_pkg::TFP_OP_CHAN, 2'h2);
      for (int i = 0; i < 16; i++) begin
         v = i[3:0];
         set_ch(v);
         chk("sum of products", {31'h0, (v[0] & v[1]) | v[2]}, {31'h0, trigger_out});
      end
   endtask : t_sum

   initial begin
      error_cnt = 0;
      compares = 0;
      t_selftest();
      t_defaults();
      t_mode();
      t_level();
      t_edge();
      t_chan();
      t_sum();
      close_out();
   end

   // Whole run needs under a thousand clocks
   initial begin
      repeat (20000) @(posedge hclk);
      error_cnt++;
      close_out();
   end
endmodule : tb_top
